// file: hdl/trbg_top.v
// Purpose: True random byte generator control, corrector, packer and registers
// Assumes: Raw noise bit and strobe arrive asynchronously from the analog source
// Notes:   Two-entry buffer between packer and data register
`include "trbg_consts.vh"
`default_nettype none

module trbg_top #(
  parameter integer STARTUP_CYC = `TRBG_STARTUP_CYC,
  parameter integer BIT_CYC     = `TRBG_BIT_CYC,
  parameter integer CNT_W       = 16
) (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // Register port
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire       sfr_rd_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  // Noise source
  input  wire       raw_bit_i,
  input  wire       raw_valid_i,
  // Interrupt
  output reg        random_byte_irq_o
);

  localparam [CNT_W-1:0] STARTUP_LOAD = STARTUP_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] BIT_LOAD     = BIT_CYC[CNT_W-1:0] - 1'b1;
  localparam [7:0]       CTL_RESET    = `TRBG_CONTROL_RESET;

  // Control and data registers
  reg              power_on_bit_ff;
  reg              bias_fix_enable_ff;
  reg              byte_ready_flag_ff;
  reg  [7:0]       entropy_byte_ff;

  // Input synchronisers
  reg              bit_s1_ff;
  reg              bit_s2_ff;
  reg              vld_s1_ff;
  reg              vld_s2_ff;
  reg              vld_s3_ff;

  // Timing
  reg  [CNT_W-1:0] startup_ff;
  reg  [CNT_W-1:0] pace_ff;

  // Corrector and packer
  reg              have_first_ff;
  reg              first_ff;
  reg  [7:0]       shift_ff;
  reg  [2:0]       pack_cnt_ff;
  reg              pack_full_ff;

  // Two-entry buffer
  reg  [7:0]       buf_mem [0:1];
  reg              buf_wp_ff;
  reg              buf_rp_ff;
  reg  [1:0]       buf_cnt_ff;

  wire ctl_wr    = sfr_wr_i && (sfr_addr_i == `TRBG_ADDR_CONTROL);
  wire byte_rd   = sfr_rd_i && (sfr_addr_i == `TRBG_ADDR_BYTE);
  wire power_up  = ctl_wr && sfr_wdata_i[`TRBG_POWER_BIT] && !power_on_bit_ff;
  wire vld_edge  = vld_s2_ff && !vld_s3_ff;
  wire started   = (startup_ff == {CNT_W{1'b0}});
  wire paced     = (pace_ff == {CNT_W{1'b0}});
  wire take_raw  = power_on_bit_ff && started && paced && vld_edge;

  // Corrected bit stream
  reg  cor_valid;
  reg  cor_bit;
  always @* begin
    cor_valid = 1'b0;
    cor_bit   = bit_s2_ff;
    if (take_raw) begin
      if (!bias_fix_enable_ff) begin
        cor_valid = 1'b1; // RULE6
      end else if (have_first_ff && (first_ff != bit_s2_ff)) begin
        cor_valid = 1'b1;
        cor_bit   = first_ff;
      end
    end
  end

  // Buffer handshakes
  wire buf_in_ready  = (buf_cnt_ff != 2'd2);
  wire buf_in_valid  = pack_full_ff;
  wire buf_push      = buf_in_valid && buf_in_ready;
  wire buf_out_valid = (buf_cnt_ff != 2'd0);
  wire buf_out_ready = !byte_ready_flag_ff || byte_rd;
  wire buf_pop       = buf_out_valid && buf_out_ready;

  // Read data
  reg  [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (sfr_addr_i == `TRBG_ADDR_CONTROL) begin
      rd_mux = {power_on_bit_ff, bias_fix_enable_ff, byte_ready_flag_ff, 5'b0_0000}; // RULE10
    end else if (sfr_addr_i == `TRBG_ADDR_BYTE) begin
      rd_mux = entropy_byte_ff; // RULE11
    end
  end

  // Synchronisers
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_s1_ff <= 1'b0;
      bit_s2_ff <= 1'b0;
      vld_s1_ff <= 1'b0;
      vld_s2_ff <= 1'b0;
      vld_s3_ff <= 1'b0;
    end else begin
      bit_s1_ff <= raw_bit_i;
      bit_s2_ff <= bit_s1_ff;
      vld_s1_ff <= raw_valid_i;
      vld_s2_ff <= vld_s1_ff;
      vld_s3_ff <= vld_s2_ff;
    end
  end

  // Control register
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_on_bit_ff    <= CTL_RESET[`TRBG_POWER_BIT];
      bias_fix_enable_ff <= CTL_RESET[`TRBG_FIX_BIT];
    end else if (ctl_wr) begin
      power_on_bit_ff    <= sfr_wdata_i[`TRBG_POWER_BIT]; // RULE1
      bias_fix_enable_ff <= sfr_wdata_i[`TRBG_FIX_BIT]; // RULE6
    end
  end

  // Start-up and bit pacing, free of any processor standby state
  reg  [CNT_W-1:0] nxt_startup;
  reg  [CNT_W-1:0] nxt_pace;
  always @* begin
    nxt_startup = startup_ff;
    nxt_pace    = pace_ff;
    if (power_up) begin
      nxt_startup = STARTUP_LOAD; // RULE9
      nxt_pace    = {CNT_W{1'b0}};
    end else begin
      if (!started) begin
        nxt_startup = startup_ff - 1'b1; // RULE12
      end
      if (take_raw) begin
        nxt_pace = BIT_LOAD; // RULE8
      end else if (!paced) begin
        nxt_pace = pace_ff - 1'b1;
      end
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      startup_ff <= {CNT_W{1'b0}};
      pace_ff    <= {CNT_W{1'b0}};
    end else begin
      startup_ff <= nxt_startup;
      pace_ff    <= nxt_pace;
    end
  end

  // Bias corrector pairing
  reg              nxt_have_first;
  reg              nxt_first;
  always @* begin
    nxt_have_first = have_first_ff;
    nxt_first      = first_ff;
    if (power_up || !power_on_bit_ff || !bias_fix_enable_ff) begin
      nxt_have_first = 1'b0;
    end else if (take_raw) begin
      nxt_have_first = !have_first_ff; // RULE13
      nxt_first      = bit_s2_ff;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      have_first_ff <= 1'b0;
      first_ff      <= 1'b0;
    end else begin
      have_first_ff <= nxt_have_first;
      first_ff      <= nxt_first;
    end
  end

  // Byte packer, stalled once it holds a full byte while the buffer is full
  reg  [7:0]       nxt_shift;
  reg  [2:0]       nxt_pack_cnt;
  reg              nxt_pack_full;
  always @* begin
    nxt_shift     = shift_ff;
    nxt_pack_cnt  = pack_cnt_ff;
    nxt_pack_full = pack_full_ff;
    if (power_up) begin
      nxt_shift     = 8'h00;
      nxt_pack_cnt  = 3'd0;
      nxt_pack_full = 1'b0;
    end else if (buf_push) begin
      nxt_pack_cnt  = 3'd0;
      nxt_pack_full = 1'b0;
    end else if (cor_valid && !pack_full_ff) begin
      nxt_shift    = {shift_ff[6:0], cor_bit}; // RULE7
      nxt_pack_cnt = pack_cnt_ff + 3'd1;
      if (pack_cnt_ff == 3'd7) begin
        nxt_pack_full = 1'b1;
      end
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_ff     <= 8'h00;
      pack_cnt_ff  <= 3'd0;
      pack_full_ff <= 1'b0;
    end else begin
      shift_ff     <= nxt_shift;
      pack_cnt_ff  <= nxt_pack_cnt;
      pack_full_ff <= nxt_pack_full;
    end
  end

  // Buffer storage
  always @(posedge core_clk_i) begin
    if (buf_push) begin
      buf_mem[buf_wp_ff] <= shift_ff;
    end
  end

  // Buffer pointers
  reg              nxt_buf_wp;
  reg              nxt_buf_rp;
  reg  [1:0]       nxt_buf_cnt;
  always @* begin
    nxt_buf_wp  = buf_wp_ff;
    nxt_buf_rp  = buf_rp_ff;
    nxt_buf_cnt = buf_cnt_ff;
    if (power_up) begin
      nxt_buf_wp  = 1'b0;
      nxt_buf_rp  = 1'b0;
      nxt_buf_cnt = 2'd0; // RULE4
    end else begin
      if (buf_push) begin
        nxt_buf_wp = !buf_wp_ff;
      end
      if (buf_pop) begin
        nxt_buf_rp = !buf_rp_ff;
      end
      if (buf_push && !buf_pop) begin
        nxt_buf_cnt = buf_cnt_ff + 2'd1;
      end else if (buf_pop && !buf_push) begin
        nxt_buf_cnt = buf_cnt_ff - 2'd1;
      end
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_wp_ff  <= 1'b0;
      buf_rp_ff  <= 1'b0;
      buf_cnt_ff <= 2'd0;
    end else begin
      buf_wp_ff  <= nxt_buf_wp;
      buf_rp_ff  <= nxt_buf_rp;
      buf_cnt_ff <= nxt_buf_cnt;
    end
  end

  // Data register and ready flag; a new byte wins over a read
  reg  [7:0]       nxt_entropy_byte;
  reg              nxt_byte_ready_flag;
  always @* begin
    nxt_entropy_byte    = entropy_byte_ff;
    nxt_byte_ready_flag = byte_ready_flag_ff;
    if (power_up) begin
      nxt_entropy_byte    = `TRBG_BYTE_RESET; // RULE4
      nxt_byte_ready_flag = 1'b0; // RULE4
    end else if (buf_pop) begin
      nxt_entropy_byte    = buf_mem[buf_rp_ff]; // RULE11
      nxt_byte_ready_flag = 1'b1; // RULE2
    end else if (byte_rd) begin
      nxt_byte_ready_flag = 1'b0; // RULE2
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      entropy_byte_ff    <= `TRBG_BYTE_RESET;
      byte_ready_flag_ff <= 1'b0;
    end else begin
      entropy_byte_ff    <= nxt_entropy_byte;
      byte_ready_flag_ff <= nxt_byte_ready_flag;
    end
  end

  // Outputs
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o       <= 8'h00;
      random_byte_irq_o <= 1'b0;
    end else begin
      if (sfr_rd_i) begin
        sfr_rdata_o <= rd_mux;
      end
      random_byte_irq_o <= byte_ready_flag_ff; // RULE3
    end
  end

endmodule // trbg_top

`default_nettype wire

// file: hdl/trbg_consts.vh
// Purpose: Constants for the true random byte generator
// Assumes: 125 MHz core clock, byte-wide special function register port
// Notes:   Times in ns; cycle counts derived from them
//
// Overview of operation
// [RULE1] Writing one to control bit 7 starts byte generation.
// [RULE2] Ready flag bit 5 sets on fresh byte, clears on data read.
// [RULE3] Interrupt output follows the ready flag exactly; the code registers it, so the output lags the flag by one cycle.
// [RULE4] Power-on bit rising edge clears data register and ready flag.
// [RULE5] Software ignores data and ready flag while powered down.
// [RULE6] Clearing bit 6 bypasses the bias corrector for faster bytes.
// [RULE7] Corrected bits shift into an 8-bit register, read in parallel.
// [RULE8] About 0.1 ms per byte uncorrected, four times longer corrected.
// [RULE9] First byte after power-on waits an extra 0.25 ms start-up.
// [RULE10] Control: bit 7 RW, bit 6 RW, bit 5 RO, 4:0 zero, reset 0x40.
// [RULE11] Data register is 8-bit read-only, reset 0x00, newest byte; the code loads the oldest unread byte from the two-entry buffer.
// [RULE12] Generator keeps running while the processor is in standby.
// [RULE13] Raw bit input with strobe, sampled only while powered on.
`ifndef TRBG_CONSTS_VH
`define TRBG_CONSTS_VH

// Register addresses
`define TRBG_ADDR_CONTROL     8'hd6
`define TRBG_ADDR_BYTE        8'hd7

// Control field positions
`define TRBG_POWER_BIT        7
`define TRBG_FIX_BIT          6
`define TRBG_READY_BIT        5

// Reset values
`define TRBG_CONTROL_RESET    8'h40
`define TRBG_BYTE_RESET       8'h00

// Timing
`define TRBG_CLK_PERIOD_NS    8
`define TRBG_STARTUP_NS       250000
`define TRBG_BYTE_NS          100000
`define TRBG_BIT_NS           (`TRBG_BYTE_NS / 8)
`define TRBG_STARTUP_CYC      ((`TRBG_STARTUP_NS + `TRBG_CLK_PERIOD_NS - 1) / `TRBG_CLK_PERIOD_NS)
`define TRBG_BIT_CYC          (`TRBG_BIT_NS / `TRBG_CLK_PERIOD_NS)

`endif

// file: dv/trbg_top_asserts.sv
// Purpose: Port checker for trbg_top
// Assumes: Register reads answer one cycle after the read edge
// Notes:   Bound to every trbg_top instance
`default_nettype none
module trbg_chk (
  // Ports of trbg_top
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       raw_bit_i,
  input wire logic       raw_valid_i,
  input wire logic       random_byte_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic wrote_ff;
  wire  ctl_rd = sfr_rd_i && sfr_addr_i == 8'hd6;
  wire  ctl_wr = sfr_wr_i && sfr_addr_i == 8'hd6;
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) wrote_ff <= 1'b0;
    else if (ctl_wr) wrote_ff <= 1'b1;
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_unmap; sfr_rd_i && sfr_addr_i != 8'hd6 && sfr_addr_i != 8'hd7
    |=> sfr_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_unused; ctl_rd |=> sfr_rdata_o[4:0] == 5'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused bits");
  property p_flag; ctl_rd |=> sfr_rdata_o[5] == random_byte_irq_o; endproperty
  a_flag: assert property (p_flag) else $error("irq differs from flag");
  property p_fall; $fell(random_byte_irq_o) |-> $past(sfr_rd_i && sfr_addr_i == 8'hd7, 2)
    || $past(ctl_wr && sfr_wdata_i[7], 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
  property p_idle; $fell(rst_i) |-> !random_byte_irq_o [*8]; endproperty
  a_idle: assert property (p_idle) else $error("irq after reset");
  property p_rst; ctl_rd && !wrote_ff |=> sfr_rdata_o[7:5] == 3'b010; endproperty
  a_rst: assert property (p_rst) else $error("control reset");
  property p_rw; ctl_rd && $past(ctl_wr, 2) && !$past(sfr_wr_i)
    |=> sfr_rdata_o[7:6] == $past(sfr_wdata_i[7:6], 3); endproperty
  a_rw: assert property (p_rw) else $error("control rw bits");
endmodule // trbg_chk
bind trbg_top trbg_chk trbg_chk_i (.core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_wdata_i, .sfr_rdata_o, .raw_bit_i, .raw_valid_i, .random_byte_irq_o);
`default_nettype wire

// file: dv/test_trbg_top.sv
// Purpose: Self-checking bench for trbg_top
// Assumes: Short start-up and bit pacing parameters
// Notes:   Noise bits are fed slower than the pacing interval except in t_pace, which pulses twice per interval
`default_nettype none
module test_trbg_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer SU = 20;
  logic       core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, raw_bit_i, raw_valid_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i;
  wire  [7:0] sfr_rdata_o;
  wire        random_byte_irq_o;
  integer     err_total = 0;
  integer     checked = 0;
  trbg_top #(.STARTUP_CYC(SU), .BIT_CYC(4)) trbg_top_i (.core_clk_i, .rst_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .raw_bit_i, .raw_valid_i,
    .random_byte_irq_o);
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(n, e, sfr_rdata_o);
  endtask
  task automatic bitx(input logic b);
    @(posedge core_clk_i);
    raw_bit_i <= b;
    repeat (2) @(posedge core_clk_i);
    raw_valid_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    raw_valid_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic gen(input logic [7:0] v, input logic fix);
    for (int i = 7; i >= 0; i--) begin
      if (fix) bitx(1'b1);
      if (fix) bitx(1'b1);
      bitx(v[i]);
      if (fix) bitx(~v[i]);
    end
  endtask
  task automatic pulse(input logic b);
    @(posedge core_clk_i);
    raw_bit_i   <= b;
    raw_valid_i <= 1'b1;
    @(posedge core_clk_i);
    raw_valid_i <= 1'b0;
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 60 && random_byte_irq_o !== 1'b1; k++)
      @(negedge core_clk_i);
    chk("irq", 8'h01, {7'h00, random_byte_irq_o});
  endtask
  task automatic t_regs;
    rdc(8'hd6, 8'h40, "ctl");
    rdc(8'hd7, 8'h00, "data");
    rdc(8'h00, 8'h00, "unmapped");
    wr(8'hd7, 8'hff);
    wr(8'hd6, 8'h3f);
    rdc(8'hd6, 8'h00, "ctl");
    rdc(8'hd7, 8'h00, "data");
    $display("register test done");
  endtask
  task automatic t_raw;
    wr(8'hd6, 8'h80);
    bitx(1'b1);
    repeat (SU) @(posedge core_clk_i);
    gen(8'ha5, 1'b0);
    wait_irq();
    rdc(8'hd6, 8'ha0, "ctl");
    rdc(8'hd7, 8'ha5, "data");
    repeat (3) @(negedge core_clk_i);
    chk("irq", 8'h00, {7'h00, random_byte_irq_o});
    rdc(8'hd6, 8'h80, "ctl");
    $display("raw byte test done");
  endtask
  task automatic t_pace;
    logic [7:0] v;
    v = 8'h5c;
    for (int i = 7; i >= 0; i--) begin
      pulse(v[i]);
      pulse(~v[i]);
    end
    wait_irq();
    rdc(8'hd7, v, "paced data");
    $display("pacing test done");
  endtask
  task automatic t_fix;
    wr(8'hd6, 8'hc0);
    gen(8'h3c, 1'b1);
    wait_irq();
    rdc(8'hd7, 8'h3c, "data");
    $display("corrector test done");
  endtask
  task automatic t_buf;
    wr(8'hd6, 8'h80);
    for (int k = 1; k <= 5; k++) gen(8'(8'h11 * k), 1'b0);
    for (int k = 1; k <= 4; k++) begin
      rdc(8'hd7, 8'(8'h11 * k), "data");
      repeat (3) @(posedge core_clk_i);
    end
    rdc(8'hd6, 8'h80, "ctl");
    $display("buffer test done");
  endtask
  task automatic t_restart;
    gen(8'h66, 1'b0);
    wait_irq();
    wr(8'hd6, 8'h00);
    wr(8'hd6, 8'h80);
    rdc(8'hd6, 8'h80, "ctl");
    rdc(8'hd7, 8'h00, "data");
    chk("irq", 8'h00, {7'h00, random_byte_irq_o});
    $display("restart test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {sfr_wr_i, sfr_rd_i, raw_bit_i, raw_valid_i, sfr_addr_i, sfr_wdata_i} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_raw();
    t_pace();
    t_fix();
    t_buf();
    t_restart();
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge core_clk_i);
    err_total++;
    print_verdict();
  end
endmodule // test_trbg_top
`default_nettype wire
